// ---- inc/cda_defines.svh ----
/*
 * Constants of the compact ALU/immediate decoder: register indices, field
 * positions, reset values and execution timing.
 * Assumes inclusion by bare name; definitions only.
 */
`ifndef CDA_DEFINES_SVH
`define CDA_DEFINES_SVH

// Register indices on the plain register port
`define CDA_ADDR_W 4
`define CDA_IDX_LOW_LAST 4'h7
`define CDA_IDX_PSW 4'h8
`define CDA_IDX_CTRL 4'h9
`define CDA_IDX_COUNT 4'ha

// Status word flag positions
`define CDA_PSW_N 31
`define CDA_PSW_Z 30
`define CDA_PSW_C 29
`define CDA_PSW_V 28

// Reset values
`define CDA_CTRL_EN_BIT 0
`define CDA_CTRL_RST 1'h1
`define CDA_FLAGS_RST 4'h0
`define CDA_REG_RST 32'h0000_0000

// Format identification
`define CDA_SHIFT_TOP 3'h0
`define CDA_ADDSUB_TOP 5'h03
`define CDA_IMM_TOP 3'h1

// Cycles from issue to completion, same as the word-wide equivalents
`define CDA_EXEC_CYCLES 1

`endif

// ---- inc/cda_pkg.sv ----
/*
 * Types of the compact ALU/immediate decoder.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
package cda_pkg;

    typedef struct packed {
        logic n;
        logic z;
        logic c;
        logic v;
    } cda_flags_type;

    typedef enum logic [1:0] {
        logical_left_shift = 2'h0,
        logical_right_shift = 2'h1,
        arithmetic_right_shift = 2'h2
    } cda_shift_type;

    typedef enum logic [1:0] {
        move_op = 2'h0,
        compare_op = 2'h1,
        add_imm_op = 2'h2,
        sub_imm_op = 2'h3
    } cda_imm_op_type;

    typedef struct packed {
        logic [3:0] addr;
        logic [31:0] wdata;
        logic wr;
        logic rd;
    } cda_bus_req_type;

endpackage

// ---- hw/cda_decoder.sv ----
/*
 * Executes shift-by-immediate, add/subtract and 8-bit immediate compact
 * instructions on eight low_bank registers and the status word flags.
 * Assumes one core clock, synchronous active-low reset, and a register
 * port master that never asserts both strobes at once.
 */
// Function
// - Shift op 00: logical left shift source by amount into destination.
// - Shift op 01: logical right shift source by amount into destination.
// - Shift op 10: arithmetic right shift source into destination.
// - Every instruction of these formats updates the status flags.
// - Add second source register to first source, write destination.
// - Add zero-extended 3-bit immediate to source, write destination.
// - Subtract second source register from first source, write result.
// - Subtract 3-bit immediate from source, write destination.
// - Immediate op 00: load zero-extended byte into destination.
// - Immediate op 01: compare by subtraction, flags only.
// - Immediate op 10: add byte to destination in place.
// - Immediate op 11: subtract byte from destination in place.
// - Each instruction takes as many cycles as its wide equivalent.
// - Add outside these formats leaves the flags unchanged.
// - Move outside the immediate format leaves the flags unchanged.
`timescale 1ns/1ps
`default_nettype none
`include "cda_defines.svh"

module cda_decoder (
    input wire logic clk_i,
    input wire logic rst_b_i,
    input wire logic instr_valid_i,
    input wire logic [15:0] instr_i,
    input wire logic [3:0] reg_addr_i,
    input wire logic [31:0] reg_wdata_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    output logic [31:0] reg_rdata_o,
    output logic done_o,
    output logic unsupported_o,
    output cda_pkg::cda_flags_type flags_o
);

    logic [31:0] regs_q [8];
    cda_pkg::cda_flags_type flags_q;
    logic en_q;
    logic [31:0] count_q;
    cda_pkg::cda_bus_req_type bus;

    logic go;
    logic is_shift;
    logic is_addsub;
    logic is_imm;
    logic [1:0] op2;
    logic [4:0] amt;
    logic [2:0] dst;
    logic [2:0] src;
    logic [2:0] fld_hi;
    logic [7:0] byte_imm;
    logic [31:0] opa;
    logic [31:0] opb;
    logic do_sub;
    logic [32:0] sum33;
    logic [32:0] sh33;
    logic [31:0] res;
    cda_pkg::cda_flags_type nf;
    logic wr_en;
    logic [2:0] wr_dst;

    assign bus = '{addr: reg_addr_i, wdata: reg_wdata_i,
                   wr: reg_wr_i, rd: reg_rd_i};
    assign go = instr_valid_i && en_q;

    // Field slicing
    assign op2 = instr_i[12:11];
    assign amt = instr_i[10:6];
    assign src = instr_i[5:3];
    assign dst = instr_i[2:0];
    assign fld_hi = instr_i[10:8];
    assign byte_imm = instr_i[7:0];
    assign is_shift = (instr_i[15:13] == `CDA_SHIFT_TOP)
                      && (op2 != 2'h3);
    assign is_addsub = (instr_i[15:11] == `CDA_ADDSUB_TOP);
    assign is_imm = (instr_i[15:13] == `CDA_IMM_TOP);

    // Shared adder: subtraction is a + ~b + 1, carry out is not-borrow
    always_comb begin
        opa = regs_q[src];
        opb = 32'h0;
        do_sub = 1'b0;
        wr_dst = dst;
        if (is_addsub) begin
            do_sub = instr_i[9];
            if (instr_i[10]) begin
                opb = {29'h0, instr_i[8:6]};
            end else begin
                opb = regs_q[instr_i[8:6]];
            end
        end else if (is_imm) begin
            wr_dst = fld_hi;
            opa = regs_q[fld_hi];
            opb = {24'h0, byte_imm};
            do_sub = op2[0];
        end
        sum33 = {1'b0, opa} + {1'b0, (do_sub ? ~opb : opb)}
                + {32'h0, do_sub};
    end

    // Barrel shift; a zero right-shift amount encodes a shift by 32
    always_comb begin
        sh33 = 33'h0;
        case (op2)
            cda_pkg::logical_left_shift: begin
                sh33 = {1'b0, regs_q[src]} << amt;
            end
            cda_pkg::logical_right_shift: begin
                if (amt == 5'h0) begin
                    sh33 = {32'h0, regs_q[src][31]};
                end else begin
                    sh33 = {regs_q[src], 1'b0} >> amt;
                end
            end
            cda_pkg::arithmetic_right_shift: begin
                if (amt == 5'h0) begin
                    sh33 = {{32{regs_q[src][31]}}, regs_q[src][31]};
                end else begin
                    sh33 = 33'($signed({regs_q[src], 1'b0}) >>> amt);
                end
            end
            default: begin
                sh33 = 33'h0;
            end
        endcase
    end

    // Result, write enable and next flags
    always_comb begin
        res = sum33[31:0];
        wr_en = 1'b0;
        nf = flags_q;
        if (is_shift) begin
            wr_en = 1'b1;
            if (op2 == cda_pkg::logical_left_shift) begin
                res = sh33[31:0];
                // Shift by zero keeps carry, as the wide move does
                nf.c = (amt == 5'h0) ? flags_q.c : sh33[32];
            end else begin
                res = sh33[32:1];
                nf.c = sh33[0];
            end
        end else if (is_addsub) begin
            wr_en = 1'b1;
            nf.c = sum33[32];
            nf.v = (opa[31] == (do_sub ? ~opb[31] : opb[31]))
                   && (sum33[31] != opa[31]);
        end else if (is_imm) begin
            if (op2 == cda_pkg::move_op) begin
                res = {24'h0, byte_imm};
                wr_en = 1'b1;
            end else begin
                wr_en = (op2 != cda_pkg::compare_op);
                nf.c = sum33[32];
                nf.v = (opa[31] == (do_sub ? ~opb[31] : opb[31]))
                       && (sum33[31] != opa[31]);
            end
        end
        nf.n = res[31];
        nf.z = (res == 32'h0);
    end

    // Register file; an executing instruction wins over a bus write
    always_ff @(posedge clk_i) begin
        if (!rst_b_i) begin
            for (int i = 0; i < 8; i++) begin
                regs_q[i] <= `CDA_REG_RST;
            end
        end else begin
            if (bus.wr && (bus.addr <= `CDA_IDX_LOW_LAST)) begin
                regs_q[bus.addr[2:0]] <= bus.wdata;
            end
            if (go && wr_en) begin
                regs_q[wr_dst] <= res;
            end
        end
    end

    // Flags change only for the three formats decoded here and on a status word write
    always_ff @(posedge clk_i) begin
        if (!rst_b_i) begin
            flags_q <= `CDA_FLAGS_RST;
        end else if (go && (is_shift || is_addsub || is_imm)) begin
            flags_q <= nf;
        end else if (bus.wr && (bus.addr == `CDA_IDX_PSW)) begin
            flags_q <= bus.wdata[`CDA_PSW_N:`CDA_PSW_V];
        end
    end

    // Control and completion count
    always_ff @(posedge clk_i) begin
        if (!rst_b_i) begin
            en_q <= `CDA_CTRL_RST;
            count_q <= 32'h0;
        end else begin
            if (bus.wr && (bus.addr == `CDA_IDX_CTRL)) begin
                en_q <= bus.wdata[`CDA_CTRL_EN_BIT];
            end
            if (bus.wr && (bus.addr == `CDA_IDX_COUNT)) begin
                count_q <= 32'h0;
            end else if (go && (is_shift || is_addsub || is_imm)) begin
                count_q <= count_q + 32'h1;
            end
        end
    end

    // Single-cycle completion matches the one-cycle wide data operations
    always_ff @(posedge clk_i) begin
        if (!rst_b_i) begin
            done_o <= 1'b0;
            unsupported_o <= 1'b0;
        end else begin
            done_o <= go && (is_shift || is_addsub || is_imm);
            unsupported_o <= go && !(is_shift || is_addsub || is_imm);
        end
    end

    always_ff @(posedge clk_i) begin
        if (!rst_b_i) begin
            flags_o <= `CDA_FLAGS_RST;
        end else begin
            flags_o <= (go && (is_shift || is_addsub || is_imm)) ? nf
                     : (bus.wr && (bus.addr == `CDA_IDX_PSW))
                       ? cda_pkg::cda_flags_type'(bus.wdata[31:28])
                       : flags_q;
        end
    end

    // Read data stands only in the cycle after the strobe
    always_ff @(posedge clk_i) begin
        if (!rst_b_i) begin
            reg_rdata_o <= 32'h0;
        end else if (!bus.rd) begin
            reg_rdata_o <= 32'h0;
        end else if (bus.addr <= `CDA_IDX_LOW_LAST) begin
            reg_rdata_o <= regs_q[bus.addr[2:0]];
        end else if (bus.addr == `CDA_IDX_PSW) begin
            reg_rdata_o <= {flags_q, 28'h0};
        end else if (bus.addr == `CDA_IDX_CTRL) begin
            reg_rdata_o <= {31'h0, en_q};
        end else if (bus.addr == `CDA_IDX_COUNT) begin
            reg_rdata_o <= count_q;
        end else begin
            reg_rdata_o <= 32'h0;
        end
    end

    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (!rst_b_i);

    lsl_write_a: assert property (
        go && is_shift && op2 == 2'h0 |=>
        regs_q[$past(dst)] == $past(regs_q[src] << amt))
        else $error("left shift result wrong");

    lsr_write_a: assert property (
        go && is_shift && op2 == 2'h1 && amt != 5'h0 |=>
        regs_q[$past(dst)] == $past(regs_q[src] >> amt))
        else $error("logical right shift result wrong");

    asr_write_a: assert property (
        go && is_shift && op2 == 2'h2 && amt != 5'h0 |=>
        regs_q[$past(dst)] == $past(32'($signed(regs_q[src]) >>> amt)))
        else $error("arithmetic right shift result wrong");

    flag_zero_a: assert property (
        go && (is_shift || is_addsub) |=>
        flags_q.z == (regs_q[$past(dst)] == 32'h0)
        && flags_q.n == regs_q[$past(dst)][31])
        else $error("zero or negative flag wrong");

    add_reg_a: assert property (
        go && is_addsub && instr_i[10:9] == 2'h0 |=>
        regs_q[$past(dst)] ==
        $past(regs_q[src] + regs_q[instr_i[8:6]]))
        else $error("register add wrong");

    add_small_a: assert property (
        go && is_addsub && instr_i[10:9] == 2'h2 |=>
        regs_q[$past(dst)] == $past(regs_q[src] + 32'(instr_i[8:6])))
        else $error("small immediate add wrong");

    sub_reg_a: assert property (
        go && is_addsub && instr_i[10:9] == 2'h1 |=>
        regs_q[$past(dst)] ==
        $past(regs_q[src] - regs_q[instr_i[8:6]]))
        else $error("register subtract wrong");

    sub_small_a: assert property (
        go && is_addsub && instr_i[10:9] == 2'h3 |=>
        regs_q[$past(dst)] == $past(regs_q[src] - 32'(instr_i[8:6]))
        && flags_q.c == $past(regs_q[src] >= 32'(instr_i[8:6])))
        else $error("small immediate subtract wrong");

    move_byte_a: assert property (
        go && is_imm && op2 == 2'h0 |=>
        regs_q[$past(fld_hi)] == {24'h0, $past(byte_imm)})
        else $error("byte move wrong");

    compare_keep_a: assert property (
        go && is_imm && op2 == 2'h1 && !reg_wr_i |=>
        regs_q[$past(fld_hi)] == $past(regs_q[fld_hi])
        && flags_q.z == $past(regs_q[fld_hi] == 32'(byte_imm)))
        else $error("compare altered register or flags wrong");

    add_byte_a: assert property (
        go && is_imm && op2 == 2'h2 |=>
        regs_q[$past(fld_hi)] == $past(regs_q[fld_hi] + 32'(byte_imm)))
        else $error("byte add wrong");

    sub_byte_a: assert property (
        go && is_imm && op2 == 2'h3 |=>
        regs_q[$past(fld_hi)] == $past(regs_q[fld_hi] - 32'(byte_imm)))
        else $error("byte subtract wrong");

    done_timing_a: assert property (
        go && (is_shift || is_addsub || is_imm) |-> ##1 done_o ##1
        !done_o || $past(go, 1))
        else $error("completion not one cycle");

    other_flags_a: assert property (
        go && !(is_shift || is_addsub || is_imm) && !reg_wr_i |=>
        $stable(flags_q) && unsupported_o)
        else $error("flags changed outside decoded formats");

endmodule

`default_nettype wire

// ---- test/tb.sv ----
/*
 * Self-checking bench for cda_decoder: issues compact instructions and
 * reaches the registers over the plain port.
 * Assumes the decoder package and header are compiled first.
 */
`timescale 1ns/1ps
`default_nettype none

module tb;
    logic clk_i = 1'h0;
    logic rst_b_i = 1'h0;
    logic instr_valid_i = 1'h0;
    logic [15:0] instr_i = 16'h0000;
    logic [3:0] reg_addr_i = 4'h0;
    logic [31:0] reg_wdata_i = 32'h0000_0000;
    logic reg_wr_i = 1'h0;
    logic reg_rd_i = 1'h0;
    logic [31:0] reg_rdata_o;
    logic done_o;
    logic unsupported_o;
    cda_pkg::cda_flags_type flags_o;
    int failures = 0;
    int num_checks = 0;

    cda_decoder cda_decoder_inst (
        .clk_i(clk_i),
        .rst_b_i(rst_b_i),
        .instr_valid_i(instr_valid_i),
        .instr_i(instr_i),
        .reg_addr_i(reg_addr_i),
        .reg_wdata_i(reg_wdata_i),
        .reg_wr_i(reg_wr_i),
        .reg_rd_i(reg_rd_i),
        .reg_rdata_o(reg_rdata_o),
        .done_o(done_o),
        .unsupported_o(unsupported_o),
        .flags_o(flags_o)
    );

    always #2.5 clk_i = ~clk_i;

    task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            failures++;
            $display("CHECK FAILED t=%0t word %h exp %h", $time, got, exp);
        end
    endtask

    task automatic chk_flags(input logic [3:0] got, input logic [3:0] exp);
        num_checks++;
        if (got !== exp) begin
            failures++;
            $display("CHECK FAILED t=%0t flags %b exp %b", $time, got, exp);
        end
    endtask

    task automatic chk_bit(input logic got, input logic exp);
        num_checks++;
        if (got !== exp) begin
            failures++;
            $display("CHECK FAILED t=%0t pulse %b exp %b", $time, got, exp);
        end
    endtask

    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge clk_i);
        reg_addr_i <= a;
        reg_wdata_i <= d;
        reg_wr_i <= 1'h1;
        @(posedge clk_i);
        reg_wr_i <= 1'h0;
    endtask

    // Read data stand only in the cycle after the strobe
    task automatic rd_chk(input logic [3:0] a, input logic [31:0] exp);
        @(posedge clk_i);
        reg_addr_i <= a;
        reg_rd_i <= 1'h1;
        @(posedge clk_i);
        reg_rd_i <= 1'h0;
        #1;
        chk_word(reg_rdata_o, exp);
        // Read data must fall back to zero one cycle later
        @(posedge clk_i);
        #1;
        chk_word(reg_rdata_o, 32'h0000_0000);
    endtask

    // Completion pulse due in the cycle right after the taking edge
    task automatic iss(input logic [15:0] i, input logic d, input logic u);
        @(posedge clk_i);
        instr_i <= i;
        instr_valid_i <= 1'h1;
        @(posedge clk_i);
        instr_valid_i <= 1'h0;
        #1;
        chk_bit(done_o, d);
        chk_bit(unsupported_o, u);
    endtask

    task automatic op(input logic [15:0] i, input logic [3:0] r,
                      input logic [31:0] v, input logic [3:0] f);
        iss(i, 1'h1, 1'h0);
        chk_flags(flags_o, f);
        rd_chk(r, v);
    endtask

    task automatic t_reset;
        rd_chk(4'h0, 32'h0000_0000);
        chk_bit(done_o, 1'h0);
        chk_bit(unsupported_o, 1'h0);
        chk_flags(flags_o, 4'h0);
        rd_chk(4'h8, 32'h0000_0000);
        rd_chk(4'h9, 32'h0000_0001);
        wr(4'hb, 32'hffff_ffff);
        rd_chk(4'hb, 32'h0000_0000);
        $display("test reset done");
    endtask

    task automatic t_shift;
        wr(4'h1, 32'h8000_0001);
        wr(4'h8, 32'h1000_0000);
        op(16'h004a, 4'h2, 32'h0000_0002, 4'b0011);
        op(16'h084b, 4'h3, 32'h4000_0000, 4'b0011);
        op(16'h110c, 4'h4, 32'hf800_0000, 4'b1001);
        op(16'h080d, 4'h5, 32'h0000_0000, 4'b0111);
        op(16'h000a, 4'h2, 32'h8000_0001, 4'b1011);
        $display("test shift done");
    endtask

    task automatic t_addsub;
        wr(4'h1, 32'h7fff_ffff);
        wr(4'h2, 32'h0000_0001);
        op(16'h188b, 4'h3, 32'h8000_0000, 4'b1001);
        op(16'h1dcc, 4'h4, 32'h8000_0006, 4'b1001);
        op(16'h1a55, 4'h5, 32'h8000_0002, 4'b1000);
        op(16'h1e56, 4'h6, 32'h0000_0000, 4'b0110);
        $display("test addsub done");
    endtask

    task automatic t_imm;
        op(16'h2780, 4'h7, 32'h0000_0080, 4'b0010);
        op(16'h2f81, 4'h7, 32'h0000_0080, 4'b1000);
        op(16'h37ff, 4'h7, 32'h0000_017f, 4'b0000);
        op(16'h3fff, 4'h7, 32'h0000_0080, 4'b0010);
        $display("test imm done");
    endtask

    // Add and move in other formats must leave the flags alone
    task automatic t_other;
        logic [15:0] tbl [4] = '{16'h4448, 16'h4608, 16'ha001, 16'hb001};
        foreach (tbl[k]) begin
            iss(tbl[k], 1'h0, 1'h1);
            chk_flags(flags_o, 4'b0010);
        end
        $display("test other done");
    endtask

    task automatic t_misc;
        wr(4'h9, 32'h0000_0000);
        iss(16'h2005, 1'h0, 1'h0);
        rd_chk(4'h0, 32'h0000_0000);
        wr(4'h9, 32'h0000_0001);
        @(posedge clk_i);
        instr_i <= 16'h2003;
        instr_valid_i <= 1'h1;
        @(posedge clk_i);
        instr_i <= 16'h3004;
        @(posedge clk_i);
        instr_valid_i <= 1'h0;
        rd_chk(4'h0, 32'h0000_0007);
        rd_chk(4'ha, 32'h0000_000f);
        wr(4'ha, 32'h0000_0000);
        rd_chk(4'ha, 32'h0000_0000);
        $display("test misc done");
    endtask

    task automatic print_verdict;
        $display("checks %0d failures %0d", num_checks, failures);
        if (failures == 0 && num_checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    initial begin
        repeat (12) @(posedge clk_i);
        rst_b_i <= 1'h1;
        t_reset();
        t_shift();
        t_addsub();
        t_imm();
        t_other();
        t_misc();
        print_verdict();
    end

    // Tests need about 130 cycles; this leaves a wide margin
    initial begin
        #50000;
        failures++;
        print_verdict();
    end
endmodule

`default_nettype wire
